/* logic/lsirq_top.sv */
// LIN sync interrupt control: control register zero, event flags and the
// interrupt request, reached over AHB-Lite.
// Assumes lin_rx comes from the transceiver pin, asynchronous to core_clk,
// and that a single master issues word-sized single transfers.
//
// Design decision made here: the AHB-Lite slave port.
module lsirq_top
	import lsirq_pkg::*;
#(
	parameter int TICK_DIV = TICK_DIV_DEF
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// LIN receive level from the transceiver
	input wire logic lin_rx,
	// Interrupt request to the processor
	output logic irq
);

	localparam int TDIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
	localparam logic [TDIV_W-1:0] TDIV_LAST = TDIV_W'(TICK_DIV - 1);

	// Pin synchroniser and edge detect
	logic rx_meta_ff, rx_sync_ff, rx_prev_ff;
	logic nxt_rx_meta, nxt_rx_sync, nxt_rx_prev;
	logic bus_low;
	logic rise_evt;

	// Only the second and third stages feed logic; the first may still be settling
	always_comb begin
		nxt_rx_meta = lin_rx;
		nxt_rx_sync = rx_meta_ff;
		nxt_rx_prev = rx_sync_ff;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			// Idle bus level, so leaving reset never looks like a rising edge
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= nxt_rx_meta;
			rx_sync_ff <= nxt_rx_sync;
			rx_prev_ff <= nxt_rx_prev;
		end
	end

	assign bus_low = !rx_sync_ff;
	assign rise_evt = rx_sync_ff && !rx_prev_ff;

	// Break timer tick divider
	// Free-running: the first count of a low period lands anywhere within one tick
	logic [TDIV_W-1:0] tdiv_ff, nxt_tdiv;
	logic tick_ff, nxt_tick;

	always_comb begin
		nxt_tdiv = tdiv_ff + 1'b1;
		nxt_tick = 1'b0;
		if (tdiv_ff == TDIV_LAST) begin
			nxt_tdiv = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			tdiv_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			tdiv_ff <= nxt_tdiv;
			tick_ff <= nxt_tick;
		end
	end

	// Software registers
	logic [CTRL0_W-1:0] ctrl0_ff, nxt_ctrl0;
	logic lin_mode_ff, nxt_lin_mode;
	logic [BRK_W-1:0] brkcmp_ff, nxt_brkcmp;
	logic [BRK_W-1:0] brk_cnt;
	logic brk_cmp_evt, brk_err_evt;

	lsirq_btmr u_btmr (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tick(tick_ff),
		.bus_low(bus_low),
		.cmp_val(brkcmp_ff),
		.cnt_ff(brk_cnt),
		.cmp_evt_ff(brk_cmp_evt),
		.err_evt_ff(brk_err_evt)
	);

	// AHB-Lite address and data phases
	lsirq_aphase_t aph_ff, nxt_aph;
	lsirq_reg_t aph_sel;
	logic [31:0] hrdata_ff, nxt_hrdata;
	logic hreadyout_ff, nxt_hreadyout;
	logic hresp_ff, nxt_hresp;
	logic take;
	logic rd_take;
	logic wr_now;
	logic stat_clr;

	// NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
	assign take = hsel && hready && htrans[HTRANS_ACT_BIT];
	assign rd_take = take && !hwrite;
	assign aph_sel = lsirq_decode(haddr);
	// Data phase of a write lands this cycle
	assign wr_now = aph_ff.vld && aph_ff.wr;

	always_comb begin
		nxt_aph.vld = take;
		nxt_aph.wr = hwrite;
		nxt_aph.sel = aph_sel;
		if (!take) begin
			nxt_aph.wr = 1'b0;
			nxt_aph.sel = REG_NONE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			aph_ff <= '{sel: REG_NONE, wr: 1'b0, vld: 1'b0};
		end else begin
			aph_ff <= nxt_aph;
		end
	end

	always_comb begin
		nxt_ctrl0 = ctrl0_ff;
		nxt_lin_mode = lin_mode_ff;
		nxt_brkcmp = brkcmp_ff;
		if (wr_now) begin
			unique case (aph_ff.sel)
				REG_CTRL0: nxt_ctrl0 = hwdata[CTRL0_W-1:0] & CTRL0_WMASK;
				REG_MODE: nxt_lin_mode = hwdata[MODE_LIN_BIT];
				REG_BRKCMP: nxt_brkcmp = hwdata[BRK_W-1:0];
				// Status, timer value and unmapped words ignore writes
				REG_STATUS, REG_BRKVAL, REG_NONE: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl0_ff <= CTRL0_RST;
			lin_mode_ff <= MODE_RST;
			brkcmp_ff <= BRKCMP_RST;
		end else begin
			ctrl0_ff <= nxt_ctrl0;
			lin_mode_ff <= nxt_lin_mode;
			brkcmp_ff <= nxt_brkcmp;
		end
	end

	// Event flags, cleared by reading the status register
	logic [STAT_W-1:0] stat_ff, nxt_stat;
	lsirq_evt_t evt;

	assign evt.rise = rise_evt;
	assign evt.cmp = brk_cmp_evt;
	assign evt.err = brk_err_evt;
	assign stat_clr = rd_take && (aph_sel == REG_STATUS);

	// A new event beats a clear in the same cycle, so no event is lost to a read
	function automatic logic lsirq_flag_next(input logic cur, input logic clr, input logic hit);
		logic v;
		v = cur;
		if (clr) begin
			v = 1'b0;
		end
		if (hit) begin
			v = 1'b1;
		end
		return v;
	endfunction

	always_comb begin
		nxt_stat = stat_ff;
		nxt_stat[STAT_RISE_BIT] = lsirq_flag_next(stat_ff[STAT_RISE_BIT], stat_clr, evt.rise);
		nxt_stat[STAT_CMP_BIT] = lsirq_flag_next(stat_ff[STAT_CMP_BIT], stat_clr, evt.cmp);
		nxt_stat[STAT_ERR_BIT] = lsirq_flag_next(stat_ff[STAT_ERR_BIT], stat_clr, evt.err);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stat_ff <= STAT_RST;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// Read data, with write data forwarded for a read straight after a write
	logic [CTRL0_W-1:0] ctrl0_view;
	logic lin_mode_view;
	logic [BRK_W-1:0] brkcmp_view;

	always_comb begin
		ctrl0_view = ctrl0_ff;
		lin_mode_view = lin_mode_ff;
		brkcmp_view = brkcmp_ff;
		if (wr_now) begin
			ctrl0_view = nxt_ctrl0;
			lin_mode_view = nxt_lin_mode;
			brkcmp_view = nxt_brkcmp;
		end
	end

	// Unmapped words and idle cycles read as zero
	always_comb begin
		nxt_hrdata = '0;
		if (rd_take) begin
			unique case (aph_sel)
				REG_STATUS: nxt_hrdata[STAT_W-1:0] = stat_ff;
				REG_CTRL0: nxt_hrdata[CTRL0_W-1:0] = ctrl0_view;
				REG_MODE: nxt_hrdata[MODE_LIN_BIT] = lin_mode_view;
				REG_BRKCMP: nxt_hrdata[BRK_W-1:0] = brkcmp_view;
				REG_BRKVAL: nxt_hrdata[BRK_W-1:0] = brk_cnt;
				REG_NONE: nxt_hrdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			hrdata_ff <= '0;
		end else begin
			hrdata_ff <= nxt_hrdata;
		end
	end

	// Zero wait states and an always-OKAY answer: every transfer ends in one data phase
	always_comb begin
		nxt_hreadyout = 1'b1;
		nxt_hresp = HRESP_OKAY;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			hreadyout_ff <= 1'b1;
			hresp_ff <= HRESP_OKAY;
		end else begin
			hreadyout_ff <= nxt_hreadyout;
			hresp_ff <= nxt_hresp;
		end
	end

	// Rise enable: bit 12 polarity flips between bit-serial and LIN mode
	function automatic logic lsirq_rise_en(input logic ctrl_bit, input logic lin_mode);
		logic allow;
		allow = !ctrl_bit;
		if (lin_mode) begin
			allow = ctrl_bit;
		end
		return allow;
	endfunction

	// Interrupt enables and request
	lsirq_evt_t en;
	logic irq_ff, nxt_irq;

	always_comb begin
		en.rise = lsirq_rise_en(ctrl0_ff[CTRL0_RISE_BIT], lin_mode_ff);
		en.cmp = !ctrl0_ff[CTRL0_CMP_BIT];
		en.err = !ctrl0_ff[CTRL0_ERR_BIT];
	end

	// Masked flags stay in status; they only lose the request
	always_comb begin
		nxt_irq = (stat_ff[STAT_RISE_BIT] && en.rise) ||
			(stat_ff[STAT_CMP_BIT] && en.cmp) ||
			(stat_ff[STAT_ERR_BIT] && en.err);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign irq = irq_ff;

	// hsize and low htrans bit are not needed: only word single transfers exist
	logic unused_ok;
	assign unused_ok = ^{hsize, htrans[0]};

endmodule

/* logic/lsirq_pkg.sv */
// Constants, types and decode helpers for the LIN sync interrupt-control block.
// Assumes one 100 MHz core clock and a single AHB-Lite master with word accesses.
//
// Notes on behaviour
// - Control register zero is 16-bit read/write and resets to 0x0000; here bits 15:13 ignore writes and read as zero.
// - Bit-serial mode: bit 12 set suppresses the rising-edge interrupt, clear allows it.
// - LIN mode: bit 12 meaning inverted; set allows, clear suppresses rising-edge interrupt.
// - Bit 11 set disables the break-timer compare interrupt, clear enables it.
// - Bit 10 set keeps the break-timer error interrupt from reaching the processor.
// - Bit 10 clear lets the break-timer error interrupt be raised.
// - Break-timer error fires when the 12-bit break timer overflows: bus low too long.
// - Break-timer compare fires when the running timer reaches the compare value.
package lsirq_pkg;

	// Register byte addresses
	localparam logic [31:0] ADDR_STATUS = 32'hFFFF_0780;
	localparam logic [31:0] ADDR_CTRL0 = 32'hFFFF_0784;
	localparam logic [31:0] ADDR_MODE = 32'hFFFF_0790;
	localparam logic [31:0] ADDR_BRKCMP = 32'hFFFF_0794;
	localparam logic [31:0] ADDR_BRKVAL = 32'hFFFF_0798;

	// Control register zero layout
	localparam int CTRL0_W = 16;
	localparam logic [15:0] CTRL0_RST = 16'h0000;
	localparam logic [15:0] CTRL0_WMASK = 16'h1FFF;
	localparam int CTRL0_RISE_BIT = 12;
	localparam int CTRL0_CMP_BIT = 11;
	localparam int CTRL0_ERR_BIT = 10;

	// Status flags
	localparam int STAT_W = 3;
	localparam int STAT_RISE_BIT = 0;
	localparam int STAT_CMP_BIT = 1;
	localparam int STAT_ERR_BIT = 2;
	localparam logic [2:0] STAT_RST = 3'h0;

	// Mode register
	localparam int MODE_LIN_BIT = 0;
	localparam logic MODE_RST = 1'h0;

	// Break timer
	localparam int BRK_W = 12;
	localparam logic [11:0] BRKCMP_RST = 12'h100;
	localparam logic [11:0] BRK_MAX = 12'hFFF;
	localparam int TICK_DIV_DEF = 16;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic HRESP_OKAY = 1'h0;
	localparam int HTRANS_ACT_BIT = 1;

	typedef enum logic [2:0] {
		REG_NONE,
		REG_STATUS,
		REG_CTRL0,
		REG_MODE,
		REG_BRKCMP,
		REG_BRKVAL
	} lsirq_reg_t;

	typedef struct packed {
		lsirq_reg_t sel;
		logic wr;
		logic vld;
	} lsirq_aphase_t;

	typedef struct packed {
		logic err;
		logic cmp;
		logic rise;
	} lsirq_evt_t;

	typedef enum {
		BT_IDLE,
		BT_COUNT,
		BT_HOLD
	} lsirq_bt_state_t;

	function automatic lsirq_reg_t lsirq_decode(input logic [31:0] addr);
		lsirq_reg_t r;
		r = REG_NONE;
		if (addr == ADDR_STATUS) r = REG_STATUS;
		if (addr == ADDR_CTRL0) r = REG_CTRL0;
		if (addr == ADDR_MODE) r = REG_MODE;
		if (addr == ADDR_BRKCMP) r = REG_BRKCMP;
		if (addr == ADDR_BRKVAL) r = REG_BRKVAL;
		return r;
	endfunction

endpackage

/* logic/lsirq_btmr.sv */
// Break timer: measures how long the LIN bus stays low, in divider ticks.
// Assumes bus_low is already synchronised to core_clk.
module lsirq_btmr
	import lsirq_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Timing and bus level
	input wire logic tick,
	input wire logic bus_low,
	input wire logic [BRK_W-1:0] cmp_val,
	// Results
	output logic [BRK_W-1:0] cnt_ff,
	output logic cmp_evt_ff,
	output logic err_evt_ff
);

	lsirq_bt_state_t state_ff, nxt_state;
	logic [BRK_W-1:0] nxt_cnt;
	logic nxt_cmp_evt, nxt_err_evt;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_cmp_evt = 1'b0;
		nxt_err_evt = 1'b0;
		unique case (state_ff)
			BT_IDLE: begin
				if (bus_low) begin
					nxt_state = BT_COUNT;
					nxt_cnt = '0;
				end
			end
			BT_COUNT: begin
				// Rising edge stops the count; value stays readable
				if (!bus_low) begin
					nxt_state = BT_IDLE;
				end else if (tick) begin
					if (cnt_ff == BRK_MAX) begin
						nxt_err_evt = 1'b1;
						nxt_state = BT_HOLD;
					end else begin
						nxt_cnt = cnt_ff + 1'b1;
						if (nxt_cnt == cmp_val) begin
							nxt_cmp_evt = 1'b1;
						end
					end
				end
			end
			BT_HOLD: begin
				// Overflow reported once per low period
				if (!bus_low) begin
					nxt_state = BT_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_ff <= BT_IDLE;
			cnt_ff <= '0;
			cmp_evt_ff <= 1'b0;
			err_evt_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			cmp_evt_ff <= nxt_cmp_evt;
			err_evt_ff <= nxt_err_evt;
		end
	end

endmodule

/* sim/lsirq_props.sv */
// Checker for the bus answer and interrupt request of lsirq_top.
// Assumes one master issuing single word transfers; bound to every lsirq_top.
module lsirq_props
	import lsirq_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Line and request
	input wire logic lin_rx,
	input wire logic irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic act;
	assign act = hsel && hready && htrans[1];
	sequence rd_at(logic [31:0] a);
		act && !hwrite && haddr == a;
	endsequence
	sequence wr_ctl;
		act && hwrite && haddr == ADDR_CTRL0;
	endsequence
	// Eight quiet cycles let any edge event settle before the clearing read
	sequence quiet_rd;
		lin_rx [*8] ##0 rd_at(ADDR_STATUS);
	endsequence
	ready_ok_a: assert property (hreadyout) else $error("hreadyout low");
	resp_ok_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	reset_quiet_a: assert property ($rose(rst_b) |-> !irq && hrdata == 32'h0)
		else $error("outputs not cleared by reset");
	ctrl_rsvd_a: assert property (rd_at(ADDR_CTRL0) |=> hrdata[31:13] == 19'h0)
		else $error("reserved control bits read nonzero");
	ctrl_rdback_a: assert property (wr_ctl ##2 rd_at(ADDR_CTRL0)
		|=> hrdata[15:0] == ($past(hwdata, 2) & CTRL0_WMASK))
		else $error("control readback differs from write");
	unmapped_zero_a: assert property (rd_at(32'hFFFF_0788) |=> hrdata == 32'h0)
		else $error("unmapped read nonzero");
	irq_clear_a: assert property (quiet_rd |-> ##2 !irq)
		else $error("irq stays after status read");
	irq_hold_a: assert property (irq && !act && !$past(act) && !$past(act, 2) |=> irq)
		else $error("irq dropped without access");
endmodule

bind lsirq_top lsirq_props i_lsirq_props (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lin_rx(lin_rx), .irq(irq));

/* sim/lsirq_lin_model.sv */
// Far-side model: LIN master pulling the bus low through the transceiver.
// Assumes a pull-up on the line, so a released bus reads recessive high.
module lsirq_lin_model (
	// Clock
	input wire logic core_clk,
	// Line
	output logic lin_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	initial lin_rx = 1'b1;
	task automatic low(input int n);
		@(posedge core_clk);
		lin_rx <= 1'b0;
		repeat (n) @(posedge core_clk);
		lin_rx <= 1'b1;
	endtask
endmodule

/* sim/lsirq_top_bench.sv */
// Bench for lsirq_top: AHB-Lite register access plus LIN low pulses.
// Assumes TICK_DIV of 1 so that timer overflow fits a short run.
module lsirq_top_bench
	import lsirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic lin_rx;
	logic irq;
	int num_errors = 0;
	int n_tests = 0;
	always #5 core_clk = ~core_clk;
	lsirq_top #(.TICK_DIV(1)) i_lsirq_top (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .lin_rx(lin_rx),
		.irq(irq));
	lsirq_lin_model i_lsirq_lin_model (.core_clk(core_clk), .lin_rx(lin_rx));
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// Entered just after an edge; hready is the slave's own hreadyout
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		rd = hrdata;
	endtask
	task automatic sc(input logic [15:0] c, input logic m, input int n, input logic ei,
		input logic [2:0] es);
		logic [31:0] d;
		bus(ADDR_MODE, 1'b1, {31'h0, m}, d);
		bus(ADDR_CTRL0, 1'b1, {16'h0, c}, d);
		bus(ADDR_STATUS, 1'b0, 32'h0, d);
		i_lsirq_lin_model.low(n);
		repeat (10) @(posedge core_clk);
		chk("irq", {31'h0, irq}, {31'h0, ei});
		bus(ADDR_STATUS, 1'b0, 32'h0, d);
		chk("status", d, {29'h0, es});
		repeat (3) @(posedge core_clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("scenario done ctrl %h mode %0d pulse %0d", c, m, n);
	endtask
	initial begin
		logic [31:0] d;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		bus(ADDR_CTRL0, 1'b0, 32'h0, d);
		chk("ctrl reset", d, 32'h0);
		bus(ADDR_CTRL0, 1'b1, 32'h0000_1FFF, d);
		bus(ADDR_CTRL0, 1'b0, 32'h0, d);
		chk("ctrl readback", d, 32'h0000_1FFF);
		bus(32'hFFFF_0788, 1'b0, 32'h0, d);
		chk("unmapped", d, 32'h0);
		bus(ADDR_BRKCMP, 1'b1, 32'h8, d);
		$display("register test done");
		// Short pulses stay below the compare value of 8, so only the edge flag sets
		sc(16'h0000, 1'b0, 4, 1'b1, 3'h1);
		sc(16'h1000, 1'b0, 4, 1'b0, 3'h1);
		sc(16'h1000, 1'b1, 4, 1'b1, 3'h1);
		sc(16'h0000, 1'b1, 4, 1'b0, 3'h1);
		sc(16'h1000, 1'b0, 30, 1'b1, 3'h3);
		sc(16'h1800, 1'b0, 30, 1'b0, 3'h3);
		sc(16'h1800, 1'b0, 4200, 1'b1, 3'h7);
		// After an overflow the timer holds its top value until the next low period
		bus(ADDR_BRKVAL, 1'b0, 32'h0, d);
		chk("timer at overflow", d, {20'h0, BRK_MAX});
		sc(16'h1C00, 1'b0, 4200, 1'b0, 3'h7);
		$display("event test done");
		finish_test;
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		num_errors++;
		finish_test;
	end
endmodule
